// >>> gpi_pkg.sv
// Shared constants and types for both ends of the instrument bus link.
package gpi_pkg;
   // ------------------------------------------------------------
   // Widths and buffering
   // ------------------------------------------------------------
   localparam int GPI_DW = 8;
   localparam int GPI_AW = 5;
   localparam int GPI_FIFO_W = 9;
   localparam int GPI_FIFO_D = 32;
   localparam logic [4:0] GPI_ADDR_MAX = 5'h1E;
   localparam logic [4:0] GPI_ADDR_RST = 5'h00;
   // ------------------------------------------------------------
   // Command bytes, seven bits, sent with attention asserted; talk group code and status byte rqs mask
   // ------------------------------------------------------------
   localparam logic [6:0] GPI_GTL = 7'h01;
   localparam logic [6:0] GPI_SDC = 7'h04;
   localparam logic [6:0] GPI_GET = 7'h08;
   localparam logic [6:0] GPI_DCL = 7'h14;
   localparam logic [6:0] GPI_SPE = 7'h18;
   localparam logic [6:0] GPI_SPD = 7'h19;
   localparam logic [6:0] GPI_LAG_BASE = 7'h20;
   localparam logic [6:0] GPI_UNL = 7'h3F;
   localparam logic [6:0] GPI_TAG_BASE = 7'h40;
   localparam logic [6:0] GPI_UNT = 7'h5F;
   localparam logic [1:0] GPI_GRP_TAG = 2'h2;
   localparam logic [7:0] GPI_RQS_MASK = 8'h40;
   // ------------------------------------------------------------
   // Handshake states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      GPI_SRC_IDLE = 2'b00,
      GPI_SRC_SETTLE = 2'b01,
      GPI_SRC_DAV = 2'b10
   } gpi_src_t;
   typedef enum logic [1:0] {
      GPI_ACC_OFF = 2'b00,
      GPI_ACC_READY = 2'b01,
      GPI_ACC_TAKEN = 2'b10
   } gpi_acc_t;
endpackage : gpi_pkg

// >>> gpi_bus_if.sv
// Open-collector instrument bus: per-party pull enables and wired levels.
`timescale 1ns/1ps
`default_nettype none
interface gpi_bus_if;
   // Pull enables, high while a party pulls the line to its asserted level.
   logic [7:0] ctl_dio_oe;
   logic [7:0] dev_dio_oe;
   logic ctl_dav_oe, dev_dav_oe;
   logic ctl_nrfd_oe, dev_nrfd_oe;
   logic ctl_ndac_oe, dev_ndac_oe;
   logic ctl_eoi_oe, dev_eoi_oe;
   logic ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe, dev_srq_oe;
   // Wired levels, high means the line is asserted by anyone.
   logic [7:0] dio;
   logic dav, nrfd, ndac, eoi, atn, ifc, ren, srq;
   assign dio = ctl_dio_oe | dev_dio_oe;
   assign dav = ctl_dav_oe | dev_dav_oe;
   assign nrfd = ctl_nrfd_oe | dev_nrfd_oe;
   assign ndac = ctl_ndac_oe | dev_ndac_oe;
   assign eoi = ctl_eoi_oe | dev_eoi_oe;
   assign atn = ctl_atn_oe;
   assign ifc = ctl_ifc_oe;
   assign ren = ctl_ren_oe;
   assign srq = dev_srq_oe;
   modport ctl (
      output ctl_dio_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe,
      output ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe,
      input dio, dav, nrfd, ndac, eoi, srq
   );
   modport dev (
      output dev_dio_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe,
      output dev_srq_oe,
      input dio, dav, nrfd, ndac, eoi, atn, ifc, ren
   );
endinterface : gpi_bus_if
`default_nettype wire

// >>> gpi_device.sv
// Instrument end: receive FIFO and talker/listener device logic.
//
// What this block does
// - Addressed commands act only once listen-addressed.
// - Controller releases all listeners with unlisten first.
// - Own listen address byte makes us listener.
// - Selective clear to a listener clears device.
// - Bytes without attention are data, not commands.
// - Send data only while talk-addressed.
// - Take data only while listen-addressed.
// - Talk, talk-only, poll reply; own listen address untalks.
// - Own talk address drops listener state.
// - Full source handshake, hold until accepted.
// - Full acceptor handshake, none lost or doubled.
// - Service request line and status byte polls.
// - Remote under remote enable; local otherwise.
// - Never answer parallel polls on data lines.
// - Universal or selective clear reinitialises device.
// - Group trigger while listener starts a reading.
// - Never drive attention, interface clear, remote.
// - Primary addresses only; ignore secondary bytes.
// - Only pull lines asserted, release otherwise.
// - Universal commands work addressed or not.
// - Take-control command is ignored.
// - Bus address limited to 0 through 30.
`timescale 1ns/1ps
`default_nettype none
module gpi_fifo
   import gpi_pkg::*;
#(
   parameter int W = GPI_FIFO_W,
   parameter int D = GPI_FIFO_D
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic clr_in,
   // Fill side
   input wire logic wr_valid_in,
   input wire logic [W-1:0] wr_data_in,
   output logic wr_ready_out,
   // Drain side
   output logic rd_valid_out,
   output logic [W-1:0] rd_data_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(D);
   localparam int CW = AW + 1;
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q, rp_q;
   logic [CW-1:0] cnt_q;
   wire push = wr_valid_in & wr_ready_out;
   wire load = (cnt_q != '0) & (~rd_valid_out | rd_ready_in);
   assign wr_ready_out = (cnt_q != CW'(D));

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rd_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else if (clr_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rd_valid_out <= 1'b0;
      end else begin
         wp_q <= wp_q + AW'(push);
         rp_q <= rp_q + AW'(load);
         cnt_q <= cnt_q + CW'(push) - CW'(load);
         if (load) begin
            rd_valid_out <= 1'b1;
            rd_data_out <= mem_q[rp_q];
         end else if (rd_ready_in) begin
            rd_valid_out <= 1'b0;
         end
      end
   end
endmodule : gpi_fifo

module gpi_device
   import gpi_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Bus
   gpi_bus_if.dev bus,
   // Configuration
   input wire logic [GPI_AW-1:0] addr_in,
   input wire logic talk_only_in,
   // Service request and status byte
   input wire logic rsv_in,
   input wire logic [GPI_DW-1:0] status_in,
   // Outgoing data
   input wire logic tx_valid_in,
   input wire logic [GPI_DW-1:0] tx_data_in,
   input wire logic tx_end_in,
   output logic tx_ready_out,
   // Incoming data
   output logic rx_valid_out,
   output logic [GPI_DW-1:0] rx_data_out,
   output logic rx_end_out,
   input wire logic rx_ready_in,
   // State and events
   output logic listener_out,
   output logic talker_out,
   output logic remote_out,
   output logic serial_poll_out,
   output logic dev_clear_out,
   output logic trigger_out
);
   // ------------------------------------------------------------
   // Bus input synchronisers
   // ------------------------------------------------------------
   logic [14:0] s1_q, s2_q;
   wire [14:0] bus_raw = {bus.dio, bus.dav, bus.nrfd, bus.ndac, bus.atn,
                          bus.eoi, bus.ifc, bus.ren};
   wire [7:0] dio_s = s2_q[14:7];
   wire dav_s = s2_q[6];
   wire nrfd_s = s2_q[5];
   wire ndac_s = s2_q[4];
   wire atn_s = s2_q[3];
   wire eoi_s = s2_q[2];
   wire ifc_s = s2_q[1];
   wire ren_s = s2_q[0];
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= bus_raw;
         s2_q <= s1_q;
      end
   end

   // ------------------------------------------------------------
   // Address and command decode
   // ------------------------------------------------------------
   logic [GPI_AW-1:0] addr_q;
   logic [7:0] rx_byte_q;
   logic rx_atn_q, rx_eoi_q, got_q;
   logic listen_q, talk_q, spe_q, polled_q;
   wire [6:0] cb = rx_byte_q[6:0];
   wire [6:0] my_lag = GPI_LAG_BASE + 7'(addr_q);
   wire [6:0] my_tag = GPI_TAG_BASE + 7'(addr_q);
   wire is_cmd = got_q & rx_atn_q;
   wire is_mla = is_cmd & (cb == my_lag);
   wire is_mta = is_cmd & (cb == my_tag);
   wire is_unl = is_cmd & (cb == GPI_UNL);
   wire is_ota = is_cmd & (cb[6:5] == GPI_GRP_TAG) & ~is_mta;
   wire is_dcl = is_cmd & (cb == GPI_DCL);
   wire is_sdc = is_cmd & (cb == GPI_SDC) & listen_q;
   wire is_gtl = is_cmd & (cb == GPI_GTL) & listen_q;
   wire is_get = is_cmd & (cb == GPI_GET) & listen_q;
   wire is_spe = is_cmd & (cb == GPI_SPE);
   wire is_spd = is_cmd & (cb == GPI_SPD);
   wire clear_ev = is_dcl | is_sdc;
   wire push_data = got_q & ~rx_atn_q & listen_q;
   wire addr_ok = (addr_in <= GPI_ADDR_MAX);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         addr_q <= GPI_ADDR_RST;
      end else if (addr_ok) begin
         addr_q <= addr_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         listen_q <= 1'b0;
         talk_q <= 1'b0;
         spe_q <= 1'b0;
      end else if (ifc_s) begin
         listen_q <= 1'b0;
         talk_q <= talk_only_in;
         spe_q <= 1'b0;
      end else begin
         if (is_mla) begin
            listen_q <= 1'b1;
         end else if (is_unl | is_mta) begin
            listen_q <= 1'b0;
         end
         if (talk_only_in | is_mta) begin
            talk_q <= 1'b1;
         end else if (is_ota | is_mla) begin
            talk_q <= 1'b0;
         end
         if (is_spe) begin
            spe_q <= 1'b1;
         end else if (is_spd) begin
            spe_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         remote_out <= 1'b0;
         dev_clear_out <= 1'b0;
         trigger_out <= 1'b0;
      end else begin
         if (!ren_s | is_gtl) begin
            remote_out <= 1'b0;
         end else if (is_mla) begin
            remote_out <= 1'b1;
         end
         dev_clear_out <= clear_ev;
         trigger_out <= is_get;
      end
   end

   // ------------------------------------------------------------
   // Acceptor handshake and receive buffer
   // ------------------------------------------------------------
   gpi_acc_t acc_q;
   logic nrfd_oe_q, ndac_oe_q;
   logic fifo_wr_ready;
   wire acc_act = atn_s | listen_q;
   wire take = (acc_q == GPI_ACC_READY) & acc_act & dav_s & ~nrfd_oe_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         acc_q <= GPI_ACC_OFF;
         nrfd_oe_q <= 1'b0;
         ndac_oe_q <= 1'b0;
      end else begin
         case (acc_q)
            GPI_ACC_OFF: begin
               // An idle acceptor releases both lines so a talker is free.
               nrfd_oe_q <= acc_act;
               ndac_oe_q <= acc_act;
               if (acc_act) begin
                  acc_q <= GPI_ACC_READY;
               end
            end
            GPI_ACC_READY: begin
               if (!acc_act) begin
                  nrfd_oe_q <= 1'b0;
                  ndac_oe_q <= 1'b0;
                  acc_q <= GPI_ACC_OFF;
               end else if (take) begin
                  nrfd_oe_q <= 1'b1;
                  ndac_oe_q <= 1'b0;
                  acc_q <= GPI_ACC_TAKEN;
               end else begin
                  nrfd_oe_q <= ~(atn_s | fifo_wr_ready);
               end
            end
            GPI_ACC_TAKEN: begin
               if (!dav_s) begin
                  ndac_oe_q <= 1'b1;
                  acc_q <= GPI_ACC_READY;
               end
            end
            default: begin
               acc_q <= GPI_ACC_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_byte_q <= 8'h00;
         rx_atn_q <= 1'b0;
         rx_eoi_q <= 1'b0;
         got_q <= 1'b0;
      end else begin
         got_q <= take;
         if (take) begin
            rx_byte_q <= dio_s;
            rx_atn_q <= atn_s;
            rx_eoi_q <= eoi_s;
         end
      end
   end

   gpi_fifo #(.W(GPI_FIFO_W), .D(GPI_FIFO_D)) u_rx_fifo (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .clr_in(clear_ev),
      .wr_valid_in(push_data),
      .wr_data_in({rx_eoi_q, rx_byte_q}),
      .wr_ready_out(fifo_wr_ready),
      .rd_valid_out(rx_valid_out),
      .rd_data_out({rx_end_out, rx_data_out}),
      .rd_ready_in(rx_ready_in)
   );

   // ------------------------------------------------------------
   // Source handshake, talker and serial poll
   // ------------------------------------------------------------
   gpi_src_t src_q;
   logic [7:0] out_byte_q, dio_oe_q;
   logic out_eoi_q, eoi_oe_q, dav_oe_q, drv_q, srq_oe_q;
   wire can_talk = talk_q & ~atn_s;
   wire tx_take = tx_valid_in & tx_ready_out;
   wire poll_load = (src_q == GPI_SRC_IDLE) & ~tx_take & can_talk & spe_q;
   wire sent = (src_q == GPI_SRC_DAV) & can_talk & ~ndac_s;
   wire [7:0] stat_byte = (status_in & ~GPI_RQS_MASK) |
                          (rsv_in ? GPI_RQS_MASK : 8'h00);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         src_q <= GPI_SRC_IDLE;
         out_byte_q <= 8'h00;
         out_eoi_q <= 1'b0;
         dio_oe_q <= 8'h00;
         eoi_oe_q <= 1'b0;
         dav_oe_q <= 1'b0;
         drv_q <= 1'b0;
      end else begin
         drv_q <= (src_q == GPI_SRC_SETTLE) & can_talk;
         case (src_q)
            GPI_SRC_IDLE: begin
               if (tx_take) begin
                  out_byte_q <= tx_data_in;
                  out_eoi_q <= tx_end_in;
                  src_q <= GPI_SRC_SETTLE;
               end else if (poll_load) begin
                  out_byte_q <= stat_byte;
                  out_eoi_q <= 1'b0;
                  src_q <= GPI_SRC_SETTLE;
               end
            end
            GPI_SRC_SETTLE: begin
               if (!talk_q) begin
                  dio_oe_q <= 8'h00;
                  eoi_oe_q <= 1'b0;
                  src_q <= GPI_SRC_IDLE;
               end else if (!can_talk) begin
                  dio_oe_q <= 8'h00;
                  eoi_oe_q <= 1'b0;
               end else begin
                  dio_oe_q <= out_byte_q;
                  eoi_oe_q <= out_eoi_q;
                  if (drv_q && !nrfd_s && ndac_s) begin
                     dav_oe_q <= 1'b1;
                     src_q <= GPI_SRC_DAV;
                  end
               end
            end
            GPI_SRC_DAV: begin
               if (!can_talk || sent) begin
                  dav_oe_q <= 1'b0;
                  dio_oe_q <= 8'h00;
                  eoi_oe_q <= 1'b0;
                  src_q <= sent ? GPI_SRC_IDLE : GPI_SRC_SETTLE;
               end
            end
            default: begin
               src_q <= GPI_SRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_ready_out <= 1'b0;
         polled_q <= 1'b0;
         srq_oe_q <= 1'b0;
      end else begin
         tx_ready_out <= (src_q == GPI_SRC_IDLE) & ~tx_take & can_talk & ~spe_q;
         if (sent && spe_q && out_byte_q[6]) begin
            polled_q <= 1'b1;
         end else if (!rsv_in) begin
            polled_q <= 1'b0;
         end
         srq_oe_q <= rsv_in & ~polled_q & ~(sent & spe_q);
      end
   end

   assign listener_out = listen_q;
   assign talker_out = talk_q;
   assign serial_poll_out = spe_q;
   assign bus.dev_dio_oe = dio_oe_q;
   assign bus.dev_dav_oe = dav_oe_q;
   assign bus.dev_eoi_oe = eoi_oe_q;
   assign bus.dev_nrfd_oe = nrfd_oe_q;
   assign bus.dev_ndac_oe = ndac_oe_q;
   assign bus.dev_srq_oe = srq_oe_q;
endmodule : gpi_device
`default_nettype wire

// >>> gpi_controller.sv
// Controller end: sends commands and data, accepts talker bytes.
`timescale 1ns/1ps
`default_nettype none
module gpi_controller
   import gpi_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Bus
   gpi_bus_if.ctl bus,
   // Bus management levels
   input wire logic atn_in,
   input wire logic ifc_in,
   input wire logic ren_in,
   input wire logic listen_in,
   // Outgoing bytes
   input wire logic cmd_valid_in,
   input wire logic [GPI_DW-1:0] cmd_byte_in,
   input wire logic cmd_end_in,
   output logic cmd_ready_out,
   // Incoming bytes
   output logic rx_valid_out,
   output logic [GPI_DW-1:0] rx_data_out,
   output logic rx_end_out,
   output logic srq_out
);
   // ------------------------------------------------------------
   // Bus input synchronisers
   // ------------------------------------------------------------
   logic [12:0] s1_q, s2_q;
   wire [12:0] bus_raw = {bus.dio, bus.dav, bus.nrfd, bus.ndac, bus.eoi,
                          bus.srq};
   wire [7:0] dio_s = s2_q[12:5];
   wire dav_s = s2_q[4];
   wire nrfd_s = s2_q[3];
   wire ndac_s = s2_q[2];
   wire eoi_s = s2_q[1];
   wire srq_s = s2_q[0];
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= bus_raw;
         s2_q <= s1_q;
      end
   end

   // ------------------------------------------------------------
   // Source handshake and management lines
   // ------------------------------------------------------------
   gpi_src_t src_q;
   logic [7:0] dio_oe_q;
   logic dav_oe_q, eoi_oe_q, atn_oe_q, ifc_oe_q, ren_oe_q, drv_q;
   wire cmd_take = cmd_valid_in & cmd_ready_out;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         src_q <= GPI_SRC_IDLE;
         dio_oe_q <= 8'h00;
         dav_oe_q <= 1'b0;
         eoi_oe_q <= 1'b0;
         atn_oe_q <= 1'b0;
         drv_q <= 1'b0;
         cmd_ready_out <= 1'b0;
      end else begin
         drv_q <= (src_q == GPI_SRC_SETTLE);
         cmd_ready_out <= (src_q == GPI_SRC_IDLE) & ~cmd_take;
         case (src_q)
            GPI_SRC_IDLE: begin
               atn_oe_q <= atn_in;
               if (cmd_take) begin
                  dio_oe_q <= cmd_byte_in;
                  eoi_oe_q <= cmd_end_in & ~atn_in;
                  src_q <= GPI_SRC_SETTLE;
               end
            end
            GPI_SRC_SETTLE: begin
               // An asserted ndac shows an acceptor is present, so no byte
               // passes before the device has seen attention change.
               if (drv_q && !nrfd_s && ndac_s) begin
                  dav_oe_q <= 1'b1;
                  src_q <= GPI_SRC_DAV;
               end
            end
            GPI_SRC_DAV: begin
               if (!ndac_s) begin
                  dav_oe_q <= 1'b0;
                  dio_oe_q <= 8'h00;
                  eoi_oe_q <= 1'b0;
                  src_q <= GPI_SRC_IDLE;
               end
            end
            default: begin
               src_q <= GPI_SRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ifc_oe_q <= 1'b0;
         ren_oe_q <= 1'b0;
         srq_out <= 1'b0;
      end else begin
         ifc_oe_q <= ifc_in;
         ren_oe_q <= ren_in;
         srq_out <= srq_s;
      end
   end

   // ------------------------------------------------------------
   // Acceptor handshake while the controller listens
   // ------------------------------------------------------------
   gpi_acc_t acc_q;
   logic nrfd_oe_q, ndac_oe_q;
   wire acc_act = listen_in & ~atn_oe_q;
   wire take = (acc_q == GPI_ACC_READY) & acc_act & dav_s & ~nrfd_oe_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         acc_q <= GPI_ACC_OFF;
         nrfd_oe_q <= 1'b0;
         ndac_oe_q <= 1'b0;
         rx_valid_out <= 1'b0;
         rx_data_out <= 8'h00;
         rx_end_out <= 1'b0;
      end else begin
         rx_valid_out <= take;
         if (take) begin
            rx_data_out <= dio_s;
            rx_end_out <= eoi_s;
         end
         case (acc_q)
            GPI_ACC_OFF: begin
               nrfd_oe_q <= 1'b0;
               ndac_oe_q <= acc_act;
               if (acc_act) begin
                  acc_q <= GPI_ACC_READY;
               end
            end
            GPI_ACC_READY: begin
               if (!acc_act) begin
                  ndac_oe_q <= 1'b0;
                  acc_q <= GPI_ACC_OFF;
               end else if (take) begin
                  nrfd_oe_q <= 1'b1;
                  ndac_oe_q <= 1'b0;
                  acc_q <= GPI_ACC_TAKEN;
               end
            end
            GPI_ACC_TAKEN: begin
               if (!dav_s) begin
                  nrfd_oe_q <= 1'b0;
                  ndac_oe_q <= 1'b1;
                  acc_q <= GPI_ACC_READY;
               end
            end
            default: begin
               acc_q <= GPI_ACC_OFF;
            end
         endcase
      end
   end

   assign bus.ctl_dio_oe = dio_oe_q;
   assign bus.ctl_dav_oe = dav_oe_q;
   assign bus.ctl_eoi_oe = eoi_oe_q;
   assign bus.ctl_atn_oe = atn_oe_q;
   assign bus.ctl_ifc_oe = ifc_oe_q;
   assign bus.ctl_ren_oe = ren_oe_q;
   assign bus.ctl_nrfd_oe = nrfd_oe_q;
   assign bus.ctl_ndac_oe = ndac_oe_q;
endmodule : gpi_controller
`default_nettype wire

// >>> gpi_bus_chk.sv
// Checker for the wired bus joining the controller and device ends.
`timescale 1ns/1ps
`default_nettype none
module gpi_bus_chk (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Bus signals
   input wire logic [7:0] dev_dio_oe,
   input wire logic dev_dav_oe, ctl_dav_oe, dev_nrfd_oe, dev_ndac_oe,
   input wire logic atn, dav, nrfd, ndac
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   property p_quiet;
      atn [*5] |-> dev_dio_oe == 8'h00 && !dev_dav_oe;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("device drives data under attention");
   property p_d_rdy;
      $rose(dev_dav_oe) |-> !$past(nrfd) && $past(ndac) && $stable(dev_dio_oe);
   endproperty
   a_d_rdy: assert property (p_d_rdy) else $error("early device dav");
   property p_c_rdy;
      $rose(ctl_dav_oe) |-> !$past(nrfd) && $past(ndac);
   endproperty
   a_c_rdy: assert property (p_c_rdy) else $error("early dav");
   property p_hold; dev_dav_oe && $past(dev_dav_oe) |-> $stable(dev_dio_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed");
   property p_d_drop;
      $fell(dev_dav_oe) && !atn && !$past(atn, 2) |-> !$past(ndac);
   endproperty
   a_d_drop: assert property (p_d_drop) else $error("device dav early");
   property p_c_drop; $fell(ctl_dav_oe) |-> !$past(ndac); endproperty
   a_c_drop: assert property (p_c_drop) else $error("dav dropped early");
   property p_take; $fell(dev_ndac_oe) && dev_nrfd_oe |-> $past(dav);
   endproperty
   a_take: assert property (p_take) else $error("take without dav");
   property p_busy; dev_nrfd_oe && !dev_ndac_oe && dav |=> dev_nrfd_oe;
   endproperty
   a_busy: assert property (p_busy) else $error("ready too soon");
   c_talk: cover property ($rose(dev_dav_oe));
   c_take: cover property ($fell(dev_ndac_oe));
   c_atn: cover property (atn ##1 !atn);
endmodule : gpi_bus_chk
`default_nettype wire

// >>> test_gpib_talker_listener_interface.sv
// Bench joining the controller and device ends over the wired bus.
`timescale 1ns/1ps
`default_nettype none
module test_gpib_talker_listener_interface;
   import gpi_pkg::*;
   logic clk_in = 1'h0, rst_b_in = 1'h0, rsv = 1'h0, trg_seen = 1'h0;
   logic atn = 1'h0, ren = 1'h0, lsn = 1'h0, cv = 1'h0, rr = 1'h1, ifc = 1'h0;
   logic tv = 1'h0, ok, cr, crv, dv, li, ta, rm, sp, dc, tg, tr, sq;
   logic [7:0] cb = 8'h00, td = 8'h00, st = 8'h00, crd, dd;
   logic [4:0] addr = 5'h10;
   logic [7:0] exp_q[$];
   int fail_count = 0, cmp_count = 0, cyc = 0, seed = 92, clr_n = 0, i;
   gpi_bus_if bus_if ();
   gpi_controller gpi_controller_inst (.clk_in, .rst_b_in, .bus(bus_if.ctl),
      .atn_in(atn), .ifc_in(ifc), .ren_in(ren), .listen_in(lsn),
      .cmd_valid_in(cv), .cmd_byte_in(cb), .cmd_end_in(1'h0),
      .cmd_ready_out(cr), .rx_valid_out(crv), .rx_data_out(crd),
      .rx_end_out(), .srq_out(sq));
   gpi_device gpi_device_inst (.clk_in, .rst_b_in, .bus(bus_if.dev),
      .addr_in(addr), .talk_only_in(1'h0), .rsv_in(rsv), .status_in(st),
      .tx_valid_in(tv), .tx_data_in(td), .tx_end_in(1'h0), .tx_ready_out(tr),
      .rx_valid_out(dv), .rx_data_out(dd), .rx_end_out(), .rx_ready_in(rr),
      .listener_out(li), .talker_out(ta), .remote_out(rm),
      .serial_poll_out(sp), .dev_clear_out(dc), .trigger_out(tg));
   gpi_bus_chk gpi_bus_chk_inst (.clk_in, .rst_b_in,
      .dev_dio_oe(bus_if.dev_dio_oe), .dev_dav_oe(bus_if.dev_dav_oe),
      .ctl_dav_oe(bus_if.ctl_dav_oe), .dev_nrfd_oe(bus_if.dev_nrfd_oe),
      .dev_ndac_oe(bus_if.dev_ndac_oe), .atn(bus_if.atn), .dav(bus_if.dav),
      .nrfd(bus_if.nrfd), .ndac(bus_if.ndac));
   initial forever #4 clk_in = ~clk_in;
   function automatic logic [7:0] cmd(input logic [6:0] c);
      return {1'h0, c};
   endfunction : cmd
   task automatic chk(input logic good);
      cmp_count++;
      if (good !== 1'h1) begin
         fail_count++;
         $display("Error at %0t: unexpected value", $time);
      end
   endtask : chk
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // Holds the byte offered until the controller takes it or 400 cycles pass.
   task automatic send(input logic a, input logic [7:0] b);
      int n;
      @(negedge clk_in);
      atn = a;
      @(negedge clk_in);
      cv = 1'h1;
      cb = b;
      if (!a) exp_q.push_back(b);
      for (n = 0; cr !== 1'h1 && n < 400; n++) @(negedge clk_in);
      @(negedge clk_in);
      cv = 1'h0;
      @(negedge clk_in);
      for (n = 0; cr !== 1'h1 && n < 40; n++) @(negedge clk_in);
      ok = cr === 1'h1;
   endtask : send
   task automatic talk(input logic [7:0] b);
      int n;
      @(negedge clk_in);
      tv = 1'h1;
      td = b;
      exp_q.push_back(b);
      for (n = 0; tr !== 1'h1 && n < 400; n++) @(negedge clk_in);
      @(negedge clk_in);
      tv = 1'h0;
   endtask : talk
   task automatic drain(input int t);
      for (i = 0; exp_q.size() != 0 && i < 900; i++) @(negedge clk_in);
      chk(exp_q.size() == 0);
      $display("Test %0d done", t);
   endtask : drain
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (dc) clr_n <= clr_n + 1;
      if (tg) trg_seen <= 1'h1;
      if ((dv && rr) || crv) begin
         chk(exp_q.size() != 0 && (dv ? dd : crd) === exp_q[0]);
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(negedge clk_in);
      rst_b_in = 1'h1;
      send(1'h1, cmd(GPI_UNL));
      send(1'h1, cmd(GPI_SDC));
      chk(li === 1'h0 && clr_n == 0);
      send(1'h1, 8'h30);
      chk(li === 1'h1);
      send(1'h1, cmd(GPI_SDC));
      chk(clr_n == 1);
      send(1'h0, 8'h2A);
      send(1'h0, 8'h52);
      rr = 1'h0;
      for (int k = 0; k < 34; k++) send(1'h0, 8'($random(seed)));
      chk(ok === 1'h0);
      rr = 1'h1;
      drain(1);
      ren = 1'h1;
      send(1'h1, cmd(GPI_LAG_BASE) + 8'(addr));
      chk(rm === 1'h1);
      send(1'h1, cmd(GPI_GTL));
      send(1'h1, cmd(GPI_GET));
      chk(rm === 1'h0 && trg_seen === 1'h1);
      addr = 5'({$random(seed)} % 31);
      send(1'h1, cmd(GPI_TAG_BASE) + 8'(addr));
      chk(ta === 1'h1 && li === 1'h0);
      chk(sq === 1'h0);
      rsv = 1'h1;
      repeat (6) @(negedge clk_in);
      chk(sq === 1'h1);
      send(1'h1, cmd(GPI_SPE));
      chk(sp === 1'h1);
      send(1'h1, cmd(GPI_SPD));
      chk(sp === 1'h0);
      lsn = 1'h1;
      @(negedge clk_in);
      atn = 1'h0;
      for (int k = 0; k < 4; k++) talk(8'($random(seed)));
      drain(2);
      send(1'h1, cmd(GPI_LAG_BASE) + 8'(addr));
      chk(ta === 1'h0 && li === 1'h1);
      ifc = 1'h1;
      repeat (6) @(negedge clk_in);
      ifc = 1'h0;
      chk(li === 1'h0 && ta === 1'h0);
      lsn = 1'h0;
      send(1'h1, cmd(GPI_UNL));
      send(1'h1, cmd(GPI_DCL));
      chk(clr_n == 2 && li === 1'h0);
      $display("Test 3 done");
      end_of_test();
   end
endmodule : test_gpib_talker_listener_interface
`default_nettype wire
